// ===== verilog/sctpc_pkg.sv
package sctpc_pkg;

  // Register offsets
  localparam logic [7:0] SLOT_CONFIG_OFS      = 8'h11;
  localparam logic [7:0] SYNC_STARTUP_OFS     = 8'h38;
  localparam logic [7:0] SAMPLE_OSC_CTRL_OFS  = 8'h4b;
  localparam logic [7:0] TIMING_OSC_TRIM_OFS  = 8'h4d;
  localparam logic [7:0] PIN_CONTROL_OFS      = 8'h4f;
  localparam logic [7:0] CLOCK_STATUS_OFS     = 8'h7f;

  // Reset values
  localparam logic [15:0] SLOT_CONFIG_RST     = 16'h1000;
  localparam logic [15:0] SYNC_STARTUP_RST    = 16'h0000;
  localparam logic [15:0] SAMPLE_OSC_CTRL_RST = 16'h2612;
  localparam logic [15:0] TIMING_OSC_TRIM_RST = 16'h0098;
  localparam logic [15:0] PIN_CONTROL_RST     = 16'h2090;

  // Field positions
  localparam int FIRST_SLOT_EN_BIT   = 0;
  localparam int OSC_BYPASS_BIT      = 8;
  localparam int CLK_POWER_UP_BIT    = 7;
  localparam int OSC_TRIM_LSB        = 0;
  localparam int OSC_TRIM_W          = 6;
  localparam int TIMING_TRIM_LSB     = 0;
  localparam int TIMING_TRIM_W       = 8;
  localparam int AUX2_OE_BIT         = 6;
  localparam int AUX2_IE_BIT         = 5;
  localparam int SYNC_SRC_LSB        = 2;
  localparam int AUX1_IE_BIT         = 1;

  // Value recommended for external sync startup
  localparam logic [15:0] SYNC_STARTUP_EXT    = 16'h4000;

  // Sample sync source codes
  typedef enum logic [1:0] {
    SCTPC_SRC_INTERNAL = 2'h0,
    SCTPC_SRC_AUX1     = 2'h1,
    SCTPC_SRC_AUX2     = 2'h2,
    SCTPC_SRC_RSVD     = 2'h3
  } sctpc_src_e;

  // Controls toward the oscillators
  typedef struct packed {
    logic                     osc_bypass;
    logic                     clk_power_up;
    logic [OSC_TRIM_W-1:0]    sample_osc_trim;
    logic [TIMING_TRIM_W-1:0] timing_osc_trim;
  } sctpc_osc_ctrl_s;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } sctpc_reg_req_s;

endpackage : sctpc_pkg

// ===== verilog/sctpc_sync3.sv
`timescale 1ns/1ns
// Three-stage synchroniser; output follows once stages two and three agree
module sctpc_sync3 (
  input  wire logic MCLK,
  input  wire logic SYS_RST,
  input  wire logic ASYNC_IN,
  output logic      SYNC_OUT
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  logic nxt_out;

  // Accept a new level only when the last two stages agree
  assign nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;

  // Stage chain
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      s1_ff  <= ASYNC_IN;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign SYNC_OUT = out_ff;

endmodule : sctpc_sync3

// ===== verilog/sctpc_clock_config.sv
`timescale 1ns/1ns
module sctpc_clock_config
  import sctpc_pkg::*;
(
  input  wire logic                       MCLK,
  input  wire logic                       SYS_RST,
  input  wire sctpc_pkg::sctpc_reg_req_s  REG_REQ,
  output logic [15:0]                     REG_RDATA,
  output logic                            REG_RVALID,
  input  wire logic                       INT_OSC_CLK,
  input  wire logic                       AUX1_I,
  input  wire logic                       AUX2_I,
  output logic                            AUX2_O,
  output logic                            AUX2_OE,
  output sctpc_pkg::sctpc_osc_ctrl_s      OSC_CTRL,
  output logic                            SAMPLE_CLK,
  output logic                            SAMPLE_TICK,
  output logic                            FIRST_SLOT_RUN,
  output logic [1:0]                      SYNC_SOURCE,
  output logic [15:0]                     SYNC_STARTUP_WORD
);

  // Stored registers
  logic [15:0]     slot_config_ff;
  logic [15:0]     sync_startup_ff;
  logic [15:0]     sample_osc_ctrl_ff;
  logic [15:0]     timing_osc_trim_ff;
  logic [15:0]     pin_control_ff;
  logic [15:0]     rdata_ff;
  logic            rvalid_ff;
  logic [15:0]     nxt_rdata;

  // Synchronised pin and oscillator levels
  logic            osc_sync;
  logic            aux1_sync;
  logic            aux2_sync;

  // Clock selection and edge tracking
  logic            first_slot_en;
  logic            osc_bypass;
  logic            clk_power_up;
  logic            aux1_ie;
  logic            aux2_ie;
  logic            aux2_oe;
  logic            aux1_level;
  logic            aux2_level;
  logic            raw_sample_clk;
  logic            gated_clk;
  logic            gated_clk_ff;
  logic            aux1_prev_ff;
  logic            aux2_prev_ff;
  logic            tick_ff;
  logic            slot_run_ff;
  logic            sample_clk_ff;
  logic            nxt_tick;
  logic            sel_internal;
  logic            sel_aux1;
  logic            sel_aux2;
  sctpc_src_e      sync_src;
  sctpc_osc_ctrl_s osc_ctrl_ff;
  sctpc_osc_ctrl_s nxt_osc_ctrl;

  // Rising edge of a sampled level
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction : rise

  // Write strobe for one offset
  function automatic logic hit(input sctpc_reg_req_s req, input logic [7:0] ofs);
    hit = req.wr && (req.addr == ofs);
  endfunction : hit

  // Input synchronisers
  sctpc_sync3 u_sync_osc (
    .MCLK     (MCLK),
    .SYS_RST  (SYS_RST),
    .ASYNC_IN (INT_OSC_CLK),
    .SYNC_OUT (osc_sync)
  );

  sctpc_sync3 u_sync_aux1 (
    .MCLK     (MCLK),
    .SYS_RST  (SYS_RST),
    .ASYNC_IN (AUX1_I),
    .SYNC_OUT (aux1_sync)
  );

  sctpc_sync3 u_sync_aux2 (
    .MCLK     (MCLK),
    .SYS_RST  (SYS_RST),
    .ASYNC_IN (AUX2_I),
    .SYNC_OUT (aux2_sync)
  );

  // Register writes; reserved bits are stored as written
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      slot_config_ff     <= SLOT_CONFIG_RST;
      sync_startup_ff    <= SYNC_STARTUP_RST;
      sample_osc_ctrl_ff <= SAMPLE_OSC_CTRL_RST;
      timing_osc_trim_ff <= TIMING_OSC_TRIM_RST;
      pin_control_ff     <= PIN_CONTROL_RST;
    end else begin
      if (hit(REG_REQ, SLOT_CONFIG_OFS)) begin
        slot_config_ff <= REG_REQ.wdata;
      end
      if (hit(REG_REQ, SYNC_STARTUP_OFS)) begin
        sync_startup_ff <= REG_REQ.wdata;
      end
      if (hit(REG_REQ, SAMPLE_OSC_CTRL_OFS)) begin
        sample_osc_ctrl_ff <= REG_REQ.wdata;
      end
      if (hit(REG_REQ, TIMING_OSC_TRIM_OFS)) begin
        timing_osc_trim_ff <= REG_REQ.wdata;
      end
      if (hit(REG_REQ, PIN_CONTROL_OFS)) begin
        pin_control_ff <= REG_REQ.wdata;
      end
    end
  end

  // Field decode
  assign first_slot_en = slot_config_ff[FIRST_SLOT_EN_BIT];
  assign osc_bypass    = sample_osc_ctrl_ff[OSC_BYPASS_BIT];
  assign clk_power_up  = sample_osc_ctrl_ff[CLK_POWER_UP_BIT];
  assign aux2_oe       = pin_control_ff[AUX2_OE_BIT];
  assign aux2_ie       = pin_control_ff[AUX2_IE_BIT];
  assign aux1_ie       = pin_control_ff[AUX1_IE_BIT];
  assign sync_src      = sctpc_src_e'(pin_control_ff[SYNC_SRC_LSB +: 2]);

  // Oscillator controls toward the analog trims
  assign nxt_osc_ctrl.osc_bypass      = osc_bypass;
  assign nxt_osc_ctrl.clk_power_up    = clk_power_up;
  assign nxt_osc_ctrl.sample_osc_trim = sample_osc_ctrl_ff[OSC_TRIM_LSB +: OSC_TRIM_W];
  assign nxt_osc_ctrl.timing_osc_trim = timing_osc_trim_ff[TIMING_TRIM_LSB +: TIMING_TRIM_W];

  // Input buffers pass the pin only while enabled
  assign aux1_level = aux1_sync & aux1_ie;
  assign aux2_level = aux2_sync & aux2_ie;

  // Bypass picks the second pin instead of the oscillator
  assign raw_sample_clk = osc_bypass ? aux2_level : osc_sync;

  // Power-up bit stops the sample clock when clear
  assign gated_clk = raw_sample_clk & clk_power_up;

  // Sync source selects what starts a sample cycle
  assign sel_internal = (sync_src == SCTPC_SRC_INTERNAL);
  assign sel_aux1     = (sync_src == SCTPC_SRC_AUX1);
  assign sel_aux2     = (sync_src == SCTPC_SRC_AUX2);

  always_comb begin
    case (sync_src)
      SCTPC_SRC_INTERNAL: nxt_tick = rise(gated_clk_ff, gated_clk);
      SCTPC_SRC_AUX1:     nxt_tick = rise(aux1_prev_ff, aux1_level);
      SCTPC_SRC_AUX2:     nxt_tick = rise(aux2_prev_ff, aux2_level);
      default:            nxt_tick = 1'b0; // Reserved code never triggers
    endcase
  end

  // Edge history, tick and slot strobes
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      gated_clk_ff  <= 1'b0;
      aux1_prev_ff  <= 1'b0;
      aux2_prev_ff  <= 1'b0;
      tick_ff       <= 1'b0;
      slot_run_ff   <= 1'b0;
      sample_clk_ff <= 1'b0;
      osc_ctrl_ff   <= '0;
    end else begin
      gated_clk_ff  <= gated_clk;
      aux1_prev_ff  <= aux1_level;
      aux2_prev_ff  <= aux2_level;
      tick_ff       <= nxt_tick;
      slot_run_ff   <= nxt_tick & first_slot_en;
      sample_clk_ff <= gated_clk;
      osc_ctrl_ff   <= nxt_osc_ctrl;
    end
  end

  // Read mux; status word shows live clock and pin state
  always_comb begin
    case (REG_REQ.addr)
      SLOT_CONFIG_OFS:     nxt_rdata = slot_config_ff;
      SYNC_STARTUP_OFS:    nxt_rdata = sync_startup_ff;
      SAMPLE_OSC_CTRL_OFS: nxt_rdata = sample_osc_ctrl_ff;
      TIMING_OSC_TRIM_OFS: nxt_rdata = timing_osc_trim_ff;
      PIN_CONTROL_OFS:     nxt_rdata = pin_control_ff;
      CLOCK_STATUS_OFS:    nxt_rdata = {9'h000, sel_aux2, sel_aux1, sel_internal,
                                        aux2_level, aux1_level, gated_clk_ff, tick_ff};
      default:             nxt_rdata = 16'h0000;
    endcase
  end

  // Read data registered one cycle after the request
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= REG_REQ.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= REG_REQ.rd;
    end
  end

  // Outputs
  assign REG_RDATA         = rdata_ff;
  assign REG_RVALID        = rvalid_ff;
  assign AUX2_O            = 1'b0;    // Output level owned by neighbouring control
  assign AUX2_OE           = aux2_oe;
  assign OSC_CTRL          = osc_ctrl_ff;
  assign SAMPLE_CLK        = sample_clk_ff;
  assign SAMPLE_TICK       = tick_ff;
  assign FIRST_SLOT_RUN    = slot_run_ff;
  assign SYNC_SOURCE       = sync_src;
  assign SYNC_STARTUP_WORD = sync_startup_ff;

endmodule : sctpc_clock_config

// ===== testbench/sctpc_clock_config_asserts.sv
`timescale 1ns/1ns
module sctpc_clock_config_asserts
  import sctpc_pkg::*;
(
  input wire logic                       MCLK,
  input wire logic                       SYS_RST,
  input wire sctpc_pkg::sctpc_reg_req_s  REG_REQ,
  input wire logic [15:0]                REG_RDATA,
  input wire logic                       REG_RVALID,
  input wire logic                       INT_OSC_CLK,
  input wire logic                       AUX1_I,
  input wire logic                       AUX2_I,
  input wire logic                       AUX2_O,
  input wire logic                       AUX2_OE,
  input wire sctpc_pkg::sctpc_osc_ctrl_s OSC_CTRL,
  input wire logic                       SAMPLE_CLK,
  input wire logic                       SAMPLE_TICK,
  input wire logic                       FIRST_SLOT_RUN,
  input wire logic [1:0]                 SYNC_SOURCE,
  input wire logic [15:0]                SYNC_STARTUP_WORD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Write strobes for the sample oscillator, timing trim and pin control registers
  wire w4b = REG_REQ.wr && REG_REQ.addr == SAMPLE_OSC_CTRL_OFS;
  wire w4d = REG_REQ.wr && REG_REQ.addr == TIMING_OSC_TRIM_OFS;
  wire w4f = REG_REQ.wr && REG_REQ.addr == PIN_CONTROL_OFS;
  // Port relations
  property p_slot; FIRST_SLOT_RUN |-> SAMPLE_TICK; endproperty
  a_slot: assert property (p_slot) else $error("slot run without tick");
  property p_oe; w4f |=> AUX2_OE == $past(REG_REQ.wdata[6]); endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  property p_src; w4f |=> SYNC_SOURCE == $past(REG_REQ.wdata[3:2]); endproperty
  a_src: assert property (p_src) else $error("sync source wrong");
  property p_osc;
    w4b |=> ##1 OSC_CTRL.osc_bypass == $past(REG_REQ.wdata[8], 2)
      && OSC_CTRL.clk_power_up == $past(REG_REQ.wdata[7], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("bypass or power-up wrong");
  property p_strim; w4b |=> ##1 OSC_CTRL.sample_osc_trim == $past(REG_REQ.wdata[5:0], 2);
  endproperty
  a_strim: assert property (p_strim) else $error("sample trim wrong");
  property p_ttrim; w4d |=> ##1 OSC_CTRL.timing_osc_trim == $past(REG_REQ.wdata[7:0], 2);
  endproperty
  a_ttrim: assert property (p_ttrim) else $error("timing trim wrong");
  property p_stop;
    (!OSC_CTRL.clk_power_up && SYNC_SOURCE == 2'h0) [*8] |-> !SAMPLE_TICK && !SAMPLE_CLK;
  endproperty
  a_stop: assert property (p_stop) else $error("clock runs while off");
  property p_rsvd; (SYNC_SOURCE == 2'h3) [*8] |-> !SAMPLE_TICK; endproperty
  a_rsvd: assert property (p_rsvd) else $error("tick on reserved source");
  property p_rst; disable iff (1'b0) SYS_RST |=> !AUX2_OE && SYNC_SOURCE == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : sctpc_clock_config_asserts
bind sctpc_clock_config sctpc_clock_config_asserts sctpc_clock_config_asserts_i (.MCLK, .SYS_RST,
  .REG_REQ, .REG_RDATA, .REG_RVALID, .INT_OSC_CLK, .AUX1_I, .AUX2_I, .AUX2_O, .AUX2_OE,
  .OSC_CTRL, .SAMPLE_CLK, .SAMPLE_TICK, .FIRST_SLOT_RUN, .SYNC_SOURCE, .SYNC_STARTUP_WORD);

// ===== testbench/sctpc_clock_config_tb.sv
`timescale 1ns/1ns
module sctpc_clock_config_tb;
  import sctpc_pkg::*;
  logic            mclk, sys_rst, int_osc_clk, aux1_i, aux2_i;
  logic            reg_rvalid, aux2_o, aux2_oe, sample_clk, sample_tick, first_slot_run;
  logic [1:0]      sync_source;
  logic [15:0]     reg_rdata, sync_startup_word, r, w;
  sctpc_reg_req_s  reg_req;
  sctpc_osc_ctrl_s osc_ctrl;
  logic [15:0]     exp_q[$];
  int              bad_count, n_compared, cyc, n_tick, n_slot, n_clk;
  logic            clk_prev;
  // Per-row setup, fixed reserved values kept
  logic [15:0] c11[8] = '{16'h1001, 16'h1000, 16'h1001, 16'h1001, 16'h1001, 16'h1001,
                          16'h1001, 16'h1001};
  logic [15:0] c4b[8] = '{16'h2680, 16'h2680, 16'h2600, 16'h2780, 16'h2780, 16'h2680,
                          16'h2680, 16'h2680};
  logic [15:0] c4f[8] = '{16'h2090, 16'h2090, 16'h2090, 16'h20b0, 16'h20b0, 16'h2096,
                          16'h20b8, 16'h20be};
  logic [2:0]  msk[8] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h1, 3'h2, 3'h1, 3'h7};
  int          et[8]  = '{4, 4, 0, 0, 4, 4, 4, 0};
  // Expected sample clock rising edges per row
  int          ec[8]  = '{4, 4, 0, 0, 4, 0, 0, 4};

  sctpc_clock_config sctpc_clock_config_i (
    .MCLK(mclk), .SYS_RST(sys_rst), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .INT_OSC_CLK(int_osc_clk), .AUX1_I(aux1_i), .AUX2_I(aux2_i),
    .AUX2_O(aux2_o), .AUX2_OE(aux2_oe), .OSC_CTRL(osc_ctrl), .SAMPLE_CLK(sample_clk),
    .SAMPLE_TICK(sample_tick), .FIRST_SLOT_RUN(first_slot_run), .SYNC_SOURCE(sync_source),
    .SYNC_STARTUP_WORD(sync_startup_word));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Compare one value
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Counts and verdict
  task automatic tally_and_finish;
    if (exp_q.size() != 0) bad_count++; // Reads that never answered
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Register write, one idle cycle after
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    reg_req = '0;
    @(negedge mclk);
  endtask : wr
  // Register read, expectation queued
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge mclk);
    reg_req = '0;
    @(negedge mclk);
  endtask : rd
  // Four rising edges on the chosen pins
  task automatic toggle(input logic [2:0] m);
    repeat (4) begin
      {int_osc_clk, aux1_i, aux2_i} = m;
      repeat (8) @(negedge mclk);
      {int_osc_clk, aux1_i, aux2_i} = 3'h0;
      repeat (8) @(negedge mclk);
    end
  endtask : toggle
  // Output watcher, tick counters and timeout
  // Sampled at the falling edge, where outputs have settled
  always @(negedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      tally_and_finish;
    end else begin
      if (reg_rvalid === 1'b1) chk("rdata", exp_q.pop_front(), reg_rdata);
      if (sample_tick === 1'b1) n_tick++;
      if (first_slot_run === 1'b1) n_slot++;
      if (sample_clk === 1'b1 && clk_prev === 1'b0) n_clk++;
      clk_prev = sample_clk;
    end
  end
  // Main sequence
  initial begin
    reg_req = '0;
    {int_osc_clk, aux1_i, aux2_i} = 3'h0;
    sys_rst = 1'b1;
    r = 16'($urandom(86));
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    rd(SLOT_CONFIG_OFS, 16'h1000);
    rd(SYNC_STARTUP_OFS, 16'h0000);
    rd(SAMPLE_OSC_CTRL_OFS, 16'h2612);
    rd(TIMING_OSC_TRIM_OFS, 16'h0098);
    rd(PIN_CONTROL_OFS, 16'h2090);
    rd(8'h20, 16'h0000);
    chk("oe", 16'h0000, {15'h0, aux2_oe});
    for (int i = 0; i < 4; i++) begin
      r = 16'($urandom()) & 16'h00ff;
      wr(TIMING_OSC_TRIM_OFS, r);
      @(negedge mclk);
      chk("ttrim", r, {8'h00, osc_ctrl.timing_osc_trim});
      rd(TIMING_OSC_TRIM_OFS, r);
    end
    for (int i = 0; i < 8; i++) begin
      r = 16'($urandom()) & 16'h003f;
      w = (c4f[i][3:2] == 2'h1 || c4f[i][3:2] == 2'h2) ? 16'h4000 : 16'h0000;
      wr(SLOT_CONFIG_OFS, c11[i]);
      wr(SAMPLE_OSC_CTRL_OFS, c4b[i] | r);
      wr(PIN_CONTROL_OFS, c4f[i]);
      wr(SYNC_STARTUP_OFS, w);
      rd(SAMPLE_OSC_CTRL_OFS, c4b[i] | r);
      rd(CLOCK_STATUS_OFS, {9'h000, (c4f[i][3:2] == 2'h2), (c4f[i][3:2] == 2'h1),
                            (c4f[i][3:2] == 2'h0), 4'h0});
      chk("strim", r, {10'h0, osc_ctrl.sample_osc_trim});
      chk("word", w, sync_startup_word);
      chk("src", {14'h0, c4f[i][3:2]}, {14'h0, sync_source});
      repeat (4) @(negedge mclk);
      n_tick = 0;
      n_slot = 0;
      n_clk = 0;
      toggle(msk[i]);
      repeat (8) @(negedge mclk);
      chk("ticks", 16'(et[i]), 16'(n_tick));
      chk("slots", c11[i][0] ? 16'(et[i]) : 16'h0000, 16'(n_slot));
      chk("clks", 16'(ec[i]), 16'(n_clk));
    end
    wr(PIN_CONTROL_OFS, 16'h20d0);
    chk("oe", 16'h0001, {15'h0, aux2_oe});
    chk("aux2_o", 16'h0000, {15'h0, aux2_o});
    rd(PIN_CONTROL_OFS, 16'h20d0);
    repeat (4) @(negedge mclk);
    tally_and_finish;
  end
endmodule : sctpc_clock_config_tb
